// [verilog/pbmc_ctrl.sv]
// Basic mode control register with its mode outputs and MII control
//
// Function
// - Loopback returns MII transmit data to receive
// - Manual speed bit: 1 is 100, 0 is 10
// - Auto-negotiation on ignores speed and duplex bits
// - Auto-negotiation off uses speed and duplex bits
// - Manual duplex bit: 1 full, 0 half
// - Power-down bit powers down, minimal register access
// - Power-down is bit ORed with low pin
// - Low pin reads back power-down bit set
// - Isolate cuts MII, management stays working
// - Restart ignored while auto-negotiation disabled
// - Restart reads 1 until initiated, then clears
// - Software clear leaves running negotiation alone
// - Collision test raises COL within 512 bits
// - Collision test drops COL within 4 bits
// - Bits 6 to 0 ignore writes, read zero
// - Speed, auto-negotiation, duplex load straps at reset
// - Self-clearing bits clear when operation completes
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module pbmc_ctrl (
  input  wire logic                         CLK,
  input  wire logic                         SYS_RST,
  input  wire logic [pbmc_pkg::ADDR_W-1:0]  REG_ADDR,
  input  wire logic [pbmc_pkg::DATA_W-1:0]  REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output logic      [pbmc_pkg::DATA_W-1:0]  REG_RDATA,
  input  wire logic                         STRAP_SPEED,
  input  wire logic                         STRAP_ANEG,
  input  wire logic                         STRAP_DUPLEX,
  input  wire logic                         POWER_DOWN_INTERRUPT_PIN_N,
  input  wire logic                         AN_INITIATED,
  input  wire logic                         AN_SPEED_100,
  input  wire logic                         AN_FULL_DUPLEX,
  output logic                              AN_RESTART_REQ,
  output logic                              SPEED_100,
  output logic                              FULL_DUPLEX,
  output logic                              ANEG_ENABLE,
  output logic                              POWER_DOWN,
  input  wire logic [3:0]                   TXD,
  input  wire logic                         TX_EN,
  input  wire logic                         TX_ER,
  output logic      [3:0]                   RXD,
  output logic                              RX_DV,
  output logic                              RX_ER,
  output logic                              COL,
  output logic                              CRS,
  output logic                              MII_RX_OE_N,
  input  wire logic [3:0]                   PCS_RXD,
  input  wire logic                         PCS_RX_DV,
  input  wire logic                         PCS_RX_ER,
  input  wire logic                         PCS_COL,
  input  wire logic                         PCS_CRS,
  output logic      [3:0]                   PCS_TXD,
  output logic                              PCS_TX_EN,
  output logic                              PCS_TX_ER
);
  import pbmc_pkg::*;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  logic           loop_q, loop_d;
  logic           speed_q, speed_d;
  logic           aneg_q, aneg_d;
  logic           pd_q, pd_d;
  logic           iso_q, iso_d;
  logic           restart_q, restart_d;
  logic           duplex_q, duplex_d;
  logic           ct_q, ct_d;
  pbmc_an_state_t an_st_q, an_st_d;
  logic           wr_hit;
  logic           pd_eff;
  logic           col_test;

  assign wr_hit = REG_WR && (REG_ADDR == BMC_OFFSET);
  assign pd_eff = pd_q | ~POWER_DOWN_INTERRUPT_PIN_N;

  always_comb
  begin
    loop_d    = loop_q;
    speed_d   = speed_q;
    aneg_d    = aneg_q;
    pd_d      = pd_q;
    iso_d     = iso_q;
    restart_d = restart_q;
    duplex_d  = duplex_q;
    ct_d      = ct_q;
    an_st_d   = an_st_q;
    // Negotiation started: request and readback bit both drop
    if (an_st_q == AN_PEND && AN_INITIATED)
    begin
      an_st_d   = AN_IDLE;
      restart_d = 1'b0;
    end
    if (wr_hit)
    begin
      pd_d = REG_WDATA[BIT_PDOWN];
      // Only the power-down bit stays writable while powered down
      if (!pd_eff)
      begin
        loop_d   = REG_WDATA[BIT_LOOPBACK];
        speed_d  = REG_WDATA[BIT_SPEED];
        aneg_d   = REG_WDATA[BIT_ANEG];
        iso_d    = REG_WDATA[BIT_ISOLATE];
        duplex_d = REG_WDATA[BIT_DUPLEX];
        ct_d     = REG_WDATA[BIT_COLTEST];
        if (REG_WDATA[BIT_RESTART])
        begin
          if (REG_WDATA[BIT_ANEG])
          begin
            restart_d = 1'b1;
            an_st_d   = AN_PEND;
          end
        end
        else
        begin
          restart_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      loop_q    <= RST_LOOPBACK;
      speed_q   <= STRAP_SPEED;
      aneg_q    <= STRAP_ANEG;
      pd_q      <= RST_PDOWN;
      iso_q     <= RST_ISOLATE;
      restart_q <= RST_RESTART;
      duplex_q  <= STRAP_DUPLEX;
      ct_q      <= RST_COLTEST;
      an_st_q   <= AN_IDLE;
    end
    else
    begin
      loop_q    <= loop_d;
      speed_q   <= speed_d;
      aneg_q    <= aneg_d;
      pd_q      <= pd_d;
      iso_q     <= iso_d;
      restart_q <= restart_d;
      duplex_q  <= duplex_d;
      ct_q      <= ct_d;
      an_st_q   <= an_st_d;
    end
  end

  assign AN_RESTART_REQ = an_st_q[0];

  // ----------------------------------------
  // Operating mode outputs
  // ----------------------------------------
  logic spd_out_q, spd_out_d, dup_out_q, dup_out_d;
  logic aneg_out_q, aneg_out_d, pd_out_q, pd_out_d;

  always_comb
  begin
    spd_out_d  = aneg_q ? AN_SPEED_100 : speed_q;
    dup_out_d  = aneg_q ? AN_FULL_DUPLEX : duplex_q;
    aneg_out_d = aneg_q;
    pd_out_d   = pd_eff;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      spd_out_q  <= 1'b0;
      dup_out_q  <= 1'b0;
      aneg_out_q <= 1'b0;
      pd_out_q   <= 1'b0;
    end
    else
    begin
      spd_out_q  <= spd_out_d;
      dup_out_q  <= dup_out_d;
      aneg_out_q <= aneg_out_d;
      pd_out_q   <= pd_out_d;
    end
  end

  assign SPEED_100   = spd_out_q;
  assign FULL_DUPLEX = dup_out_q;
  assign ANEG_ENABLE = aneg_out_q;
  assign POWER_DOWN  = pd_out_q;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [DATA_W-1:0] rdata_q, rdata_d;

  always_comb
  begin
    rdata_d = '0;
    if (REG_RD && REG_ADDR == BMC_OFFSET)
    begin
      rdata_d[BIT_LOOPBACK] = loop_q;
      rdata_d[BIT_SPEED]    = speed_q;
      rdata_d[BIT_ANEG]     = aneg_q;
      rdata_d[BIT_PDOWN]    = pd_eff;
      rdata_d[BIT_ISOLATE]  = iso_q;
      rdata_d[BIT_RESTART]  = restart_q;
      rdata_d[BIT_DUPLEX]   = duplex_q;
      rdata_d[BIT_COLTEST]  = ct_q;
      rdata_d               = rdata_d & ~RESERVED_MASK;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  assign REG_RDATA = rdata_q;

  // ----------------------------------------
  // MII side
  // ----------------------------------------
  pbmc_col_test u_col_test (
    .CLK      (CLK),
    .SYS_RST  (SYS_RST),
    .enable   (ct_q & ~iso_q),
    .tx_en    (TX_EN),
    .col_test (col_test)
  );

  pbmc_mii_path u_mii_path (
    .CLK         (CLK),
    .SYS_RST     (SYS_RST),
    .loopback    (loop_q),
    .isolate     (iso_q),
    .col_test_en (ct_q),
    .col_test    (col_test),
    .txd         (TXD),
    .tx_en       (TX_EN),
    .tx_er       (TX_ER),
    .pcs_rxd     (PCS_RXD),
    .pcs_rx_dv   (PCS_RX_DV),
    .pcs_rx_er   (PCS_RX_ER),
    .pcs_col     (PCS_COL),
    .pcs_crs     (PCS_CRS),
    .rxd         (RXD),
    .rx_dv       (RX_DV),
    .rx_er       (RX_ER),
    .col         (COL),
    .crs         (CRS),
    .rx_oe_n     (MII_RX_OE_N),
    .pcs_txd     (PCS_TXD),
    .pcs_tx_en   (PCS_TX_EN),
    .pcs_tx_er   (PCS_TX_ER)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_speed_manual: assert property (!aneg_q |=> SPEED_100 == $past(speed_q))
    else $error("manual speed not applied");

  a_duplex_manual: assert property (!aneg_q |=> FULL_DUPLEX == $past(duplex_q))
    else $error("manual duplex not applied");

  a_aneg_override: assert property (aneg_q |=>
    SPEED_100 == $past(AN_SPEED_100) && FULL_DUPLEX == $past(AN_FULL_DUPLEX))
    else $error("manual bits used while negotiating");

  a_pdown_or: assert property (1'b1 |=> POWER_DOWN == $past(pd_q | ~POWER_DOWN_INTERRUPT_PIN_N))
    else $error("power-down output is not the OR of bit and pin");

  a_pdown_read: assert property (REG_RD && REG_ADDR == BMC_OFFSET && !POWER_DOWN_INTERRUPT_PIN_N
    |=> REG_RDATA[BIT_PDOWN])
    else $error("power-down bit not read as set while pin is low");

  a_pdown_lock: assert property (wr_hit && pd_eff |=> iso_q == $past(iso_q) && loop_q == $past(loop_q))
    else $error("control bits written during power-down");

  a_restart_ignore: assert property (wr_hit && !REG_WDATA[BIT_ANEG] && an_st_q == AN_IDLE
    |=> an_st_q == AN_IDLE)
    else $error("restart taken with negotiation disabled");

  a_restart_hold: assert property (restart_q && !AN_INITIATED && !wr_hit |=> restart_q)
    else $error("restart bit cleared before negotiation started");

  a_restart_clear: assert property (an_st_q == AN_PEND && AN_INITIATED && !wr_hit
    |=> !restart_q && !AN_RESTART_REQ)
    else $error("restart bit did not self-clear");

  a_sw_clear_keep: assert property (an_st_q == AN_PEND && wr_hit && !REG_WDATA[BIT_RESTART]
    && !AN_INITIATED && !pd_eff |=> AN_RESTART_REQ && !restart_q)
    else $error("software clear disturbed pending negotiation");

  a_reserved_zero: assert property (REG_RD |=> REG_RDATA[6:0] == 7'h00)
    else $error("reserved bits not zero");

  a_strap_load: assert property ($fell(SYS_RST) |->
    speed_q == $past(STRAP_SPEED) && aneg_q == $past(STRAP_ANEG) && duplex_q == $past(STRAP_DUPLEX))
    else $error("strap defaults not loaded at reset");

endmodule : pbmc_ctrl

// [verilog/pbmc_pkg.sv]
// Constants and types for the basic mode control register block
package pbmc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned     ADDR_W         = 5;
  localparam int unsigned     DATA_W         = 16;
  localparam logic [4:0]      BMC_OFFSET     = 5'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned     BIT_LOOPBACK   = 14;
  localparam int unsigned     BIT_SPEED      = 13;
  localparam int unsigned     BIT_ANEG       = 12;
  localparam int unsigned     BIT_PDOWN      = 11;
  localparam int unsigned     BIT_ISOLATE    = 10;
  localparam int unsigned     BIT_RESTART    = 9;
  localparam int unsigned     BIT_DUPLEX     = 8;
  localparam int unsigned     BIT_COLTEST    = 7;
  localparam logic [15:0]     RESERVED_MASK  = 16'h007F;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic            RST_LOOPBACK   = 1'b0;
  localparam logic            RST_PDOWN      = 1'b0;
  localparam logic            RST_ISOLATE    = 1'b0;
  localparam logic            RST_RESTART    = 1'b0;
  localparam logic            RST_COLTEST    = 1'b0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned     CLK_PERIOD_NS      = 10;
  localparam int unsigned     BIT_TIME_FAST_NS   = 10;
  localparam int unsigned     COL_ON_BITS        = 512;
  localparam int unsigned     COL_OFF_BITS       = 4;
  // Longest times, rounded down, at the fastest bit rate
  localparam int unsigned     COL_ON_CYC  = (COL_ON_BITS * BIT_TIME_FAST_NS) / CLK_PERIOD_NS;
  localparam int unsigned     COL_OFF_CYC = (COL_OFF_BITS * BIT_TIME_FAST_NS) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    AN_IDLE = 1'b0,
    AN_PEND = 1'b1
  } pbmc_an_state_t;

endpackage : pbmc_pkg

// [verilog/pbmc_col_test.sv]
// Collision test signal generator
`timescale 1ns/1ps
module pbmc_col_test (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic enable,
  input  wire logic tx_en,
  output logic      col_test
);
  import pbmc_pkg::*;

  logic col_q;
  logic col_d;

  always_comb
  begin
    col_d = enable & tx_en;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      col_q <= 1'b0;
    else
      col_q <= col_d;
  end

  assign col_test = col_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_tx_start;
    enable && $rose(tx_en);
  endsequence

  sequence s_tx_stop;
    enable && $fell(tx_en);
  endsequence

  a_col_rise_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_tx_start ##0 (enable && tx_en) [*2] |-> col_q)
    else $error("collision test signal late after transmit enable");

  a_col_fall_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_tx_stop |=> !col_q)
    else $error("collision test signal held after transmit enable fell");

endmodule : pbmc_col_test

// [verilog/pbmc_mii_path.sv]
// MII data path with loopback and isolation
`timescale 1ns/1ps
module pbmc_mii_path (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       loopback,
  input  wire logic       isolate,
  input  wire logic       col_test_en,
  input  wire logic       col_test,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  input  wire logic [3:0] pcs_rxd,
  input  wire logic       pcs_rx_dv,
  input  wire logic       pcs_rx_er,
  input  wire logic       pcs_col,
  input  wire logic       pcs_crs,
  output logic      [3:0] rxd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic            col,
  output logic            crs,
  output logic            rx_oe_n,
  output logic      [3:0] pcs_txd,
  output logic            pcs_tx_en,
  output logic            pcs_tx_er
);
  import pbmc_pkg::*;

  logic [3:0] rxd_q, rxd_d, ptxd_q, ptxd_d;
  logic       dv_q, dv_d, er_q, er_d, col_q, col_d, crs_q, crs_d;
  logic       oe_n_q, oe_n_d, pten_q, pten_d, pter_q, pter_d;

  always_comb
  begin
    rxd_d  = pcs_rxd;
    dv_d   = pcs_rx_dv;
    er_d   = pcs_rx_er;
    crs_d  = pcs_crs;
    col_d  = col_test_en ? col_test : pcs_col;
    ptxd_d = txd;
    pten_d = tx_en;
    pter_d = tx_er;
    oe_n_d = 1'b0;
    if (loopback)
    begin
      rxd_d  = txd;
      dv_d   = tx_en;
      er_d   = tx_er;
      crs_d  = tx_en;
      pten_d = 1'b0;
    end
    if (isolate)
    begin
      rxd_d  = 4'h0;
      dv_d   = 1'b0;
      er_d   = 1'b0;
      crs_d  = 1'b0;
      col_d  = 1'b0;
      ptxd_d = 4'h0;
      pten_d = 1'b0;
      pter_d = 1'b0;
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      rxd_q  <= 4'h0;
      dv_q   <= 1'b0;
      er_q   <= 1'b0;
      col_q  <= 1'b0;
      crs_q  <= 1'b0;
      oe_n_q <= 1'b1;
      ptxd_q <= 4'h0;
      pten_q <= 1'b0;
      pter_q <= 1'b0;
    end
    else
    begin
      rxd_q  <= rxd_d;
      dv_q   <= dv_d;
      er_q   <= er_d;
      col_q  <= col_d;
      crs_q  <= crs_d;
      oe_n_q <= oe_n_d;
      ptxd_q <= ptxd_d;
      pten_q <= pten_d;
      pter_q <= pter_d;
    end
  end

  assign rxd       = rxd_q;
  assign rx_dv     = dv_q;
  assign rx_er     = er_q;
  assign col       = col_q;
  assign crs       = crs_q;
  assign rx_oe_n   = oe_n_q;
  assign pcs_txd   = ptxd_q;
  assign pcs_tx_en = pten_q;
  assign pcs_tx_er = pter_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_loop_return: assert property (@(posedge CLK) disable iff (SYS_RST)
    loopback && !isolate |=> rxd_q == $past(txd) && dv_q == $past(tx_en) && !pten_q)
    else $error("loopback did not return transmit data");

  a_isolate_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
    isolate |=> oe_n_q && !pten_q && !dv_q)
    else $error("isolated port still drives the MII");

endmodule : pbmc_mii_path

// [sim/pbmc_an_model.sv]
// Negotiation engine model that answers restart requests after a set delay
`timescale 1ns/1ps
module pbmc_an_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       restart_req,
  input  wire logic [7:0] delay,
  output logic            initiated,
  output logic            speed_100,
  output logic            full_duplex
);
  logic [7:0] cnt_q;
  logic       done_q;

  // Negotiated result: 10 Mb/s full duplex; the speed differs from the strap values, the duplex does not
  assign speed_100   = 1'b0;
  assign full_duplex = 1'b1;

  // One pulse per request; waits for the request to drop before rearming
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q     <= 8'h00;
      done_q    <= 1'b0;
      initiated <= 1'b0;
    end
    else
    begin
      initiated <= 1'b0;
      if (!restart_req)
      begin
        cnt_q  <= 8'h00;
        done_q <= 1'b0;
      end
      else if (!done_q)
      begin
        if (cnt_q == delay)
        begin
          initiated <= 1'b1;
          done_q    <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : pbmc_an_model

// [sim/tb_phy_basic_mode_control.sv]
// Self-checking bench for the basic mode control register block
`timescale 1ns/1ps
module tb_phy_basic_mode_control;
  import pbmc_pkg::*;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic [4:0]  addr   = 5'h00;
  logic [15:0] wdata  = 16'h0000;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic [2:0]  strap  = 3'h7;
  logic        pin_n  = 1'b1;
  logic [7:0]  dly    = 8'h14;
  logic [3:0]  txd    = 4'h0;
  logic        tx_en  = 1'b0;
  logic        tx_er  = 1'b0;
  logic [3:0]  prxd   = 4'h0;
  logic        prx_dv = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  rxd, ptxd;
  logic        an_init, an_spd, an_fdx, req, spd, fdx, aneg_en, pdn;
  logic        rx_dv, rx_er, col, crs, oe_n, ptx_en, ptx_er;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          i;
  int          n;

  always #5 clk = ~clk;

  pbmc_an_model an_u (.clk(clk), .rst(rst), .restart_req(req), .delay(dly), .initiated(an_init),
    .speed_100(an_spd), .full_duplex(an_fdx));

  pbmc_ctrl dut_u (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .STRAP_SPEED(strap[2]), .STRAP_ANEG(strap[1]),
    .STRAP_DUPLEX(strap[0]), .POWER_DOWN_INTERRUPT_PIN_N(pin_n), .AN_INITIATED(an_init),
    .AN_SPEED_100(an_spd), .AN_FULL_DUPLEX(an_fdx), .AN_RESTART_REQ(req), .SPEED_100(spd),
    .FULL_DUPLEX(fdx), .ANEG_ENABLE(aneg_en), .POWER_DOWN(pdn), .TXD(txd), .TX_EN(tx_en),
    .TX_ER(tx_er), .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .COL(col), .CRS(crs),
    .MII_RX_OE_N(oe_n), .PCS_RXD(prxd), .PCS_RX_DV(prx_dv), .PCS_RX_ER(1'b0), .PCS_COL(1'b0),
    .PCS_CRS(1'b0), .PCS_TXD(ptxd), .PCS_TX_EN(ptx_en), .PCS_TX_ER(ptx_er));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk16(rdata, exp);
  endtask : rd_chk

  // Waits for restart request (sel 0) or collision (sel 1) to reach lvl
  task automatic wait_until(input int sel, input logic lvl, input int lim);
    #1;
    n = 0;
    n_tests++;
    while (((sel == 0) ? req : col) !== lvl && n <= lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n > lim)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t wait ran out after %0d cycles", $time, n);
      print_verdict();
    end
  endtask : wait_until

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    rst   <= 1'b1;
    strap <= s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  function automatic logic [15:0] mii_view();
    return {crs, rx_er, ptx_er, 1'b0, oe_n, rx_dv, ptx_en, col, rxd, ptxd};
  endfunction : mii_view

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    do_reset(3'b111);
    rd_chk(5'h00, 16'h3100);
    chk1(aneg_en, 1'b1);
    chk1(spd, 1'b0);
    wr_reg(5'h00, 16'h1000);
    cyc(3);
    chk1(fdx, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      wr_reg(5'h00, {2'b00, i[1], 4'h0, i[0], 8'h00});
      cyc(3);
      chk1(spd, i[1]);
      chk1(fdx, i[0]);
    end
    wr_reg(5'h00, 16'h217F);
    rd_chk(5'h00, 16'h2100);
    wr_reg(5'h03, 16'hFFFF);
    rd_chk(5'h03, 16'h0000);
    rd_chk(5'h00, 16'h2100);
    wr_reg(5'h00, 16'h0200);
    cyc(1);
    chk1(req, 1'b0);
    rd_chk(5'h00, 16'h0000);
    wr_reg(5'h00, 16'h1200);
    cyc(1);
    chk1(req, 1'b1);
    rd_chk(5'h00, 16'h1200);
    wait_until(0, 1'b0, 40);
    rd_chk(5'h00, 16'h1000);
    wr_reg(5'h00, 16'h1200);
    wr_reg(5'h00, 16'h1000);
    cyc(1);
    chk1(req, 1'b1);
    rd_chk(5'h00, 16'h1000);
    wait_until(0, 1'b0, 40);
    dly <= 8'h00;
    wr_reg(5'h00, 16'h1200);
    wait_until(0, 1'b0, 4);
    wr_reg(5'h00, 16'h0800);
    cyc(2);
    chk1(pdn, 1'b1);
    wr_reg(5'h00, 16'h0100);
    rd_chk(5'h00, 16'h0000);
    @(posedge clk);
    pin_n <= 1'b0;
    cyc(2);
    chk1(pdn, 1'b1);
    rd_chk(5'h00, 16'h0800);
    @(posedge clk);
    pin_n <= 1'b1;
    wr_reg(5'h00, 16'h0000);
    cyc(2);
    chk1(pdn, 1'b0);
    @(posedge clk);
    prxd   <= 4'h5;
    prx_dv <= 1'b1;
    txd    <= 4'hA;
    tx_en  <= 1'b1;
    tx_er  <= 1'b1;
    cyc(2);
    chk16(mii_view(), 16'h265A);
    wr_reg(5'h00, 16'h4000);
    for (i = 0; i < 16; i += 5)
    begin
      txd <= i[3:0];
      cyc(3);
      chk16(mii_view() & 16'hFFF0, {8'hE4, i[3:0], 4'h0});
    end
    wr_reg(5'h00, 16'h0400);
    cyc(2);
    chk16(mii_view(), 16'h0800);
    rd_chk(5'h00, 16'h0400);
    tx_en <= 1'b0;
    wr_reg(5'h00, 16'h0080);
    cyc(3);
    @(posedge clk);
    tx_en <= 1'b1;
    wait_until(1, 1'b1, int'(COL_ON_CYC));
    @(posedge clk);
    tx_en <= 1'b0;
    wait_until(1, 1'b0, int'(COL_OFF_CYC));
    do_reset(3'b101);
    rd_chk(5'h00, 16'h2100);
    cyc(1);
    chk1(aneg_en, 1'b0);
    chk1(spd, 1'b1);
    chk1(fdx, 1'b1);
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED t=%0t run limit reached", $time);
    print_verdict();
  end
endmodule : tb_phy_basic_mode_control
